// ### hdl/buck_regs_pkg.sv
// buck_regs_pkg: register map, field positions and voltage constants
// shared by the buck regulator control register bank.
package buck_regs_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_BUCK = 2;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_A_STANDBY = 6'h10;
	localparam logic [5:0] IDX_A_RESERVED = 6'h11;
	localparam logic [5:0] IDX_A_CONTROL = 6'h12;
	localparam logic [5:0] IDX_A_MAIN = 6'h13;
	localparam logic [5:0] IDX_B_STANDBY = 6'h20;
	localparam logic [5:0] IDX_B_RESERVED = 6'h21;
	localparam logic [5:0] IDX_B_CONTROL = 6'h22;
	localparam logic [5:0] IDX_B_MAIN = 6'h23;

	// field positions
	localparam int CODE_MSB = 5;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_PGOOD_BIT = 1;
	localparam int CTRL_FMASK_BIT = 2;
	localparam int MAIN_RANGE_BIT = 6;

	// reset values
	localparam logic [5:0] RST_CODE = 6'h00;
	localparam logic RST_RANGE = 1'b0;
	localparam logic RST_ENABLE = 1'b0;
	localparam logic RST_FMASK = 1'b0;
	localparam logic [7:0] RESERVED_VALUE = 8'h00;

	// voltage decode, millivolts
	localparam int MV_W = 13;
	localparam logic [5:0] CODE_ADJUSTABLE = 6'h00;
	localparam logic [5:0] LOW_FLAT_LAST = 6'h07;
	localparam logic [5:0] LOW_ODD_CODE = 6'h22;
	localparam logic [MV_W-1:0] LOW_BASE_MV = 13'h0320;
	localparam logic [MV_W-1:0] LOW_STEP_MV = 13'h0019;
	localparam logic [MV_W-1:0] LOW_ODD_MV = 13'h05c8;
	localparam logic [MV_W-1:0] HIGH_BASE_MV = 13'h0514;
	localparam logic [MV_W-1:0] HIGH_STEP_MV = 13'h0032;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ### hdl/buck_regulator_control_regs.sv
// buck_regulator_control_regs: control/status bank for two step-down regulators
// behind an AXI4-Lite slave. Power-good and standby arrive as asynchronous pins.
// Overview of operation
// - buck a standby code, bits 5:0, index 10h
// - buck a main code, bits 5:0, index 13h
// - control: enable, power-good, fault mask
// - fault mask bit gates fault reporting
// - reserved byte and bits are read-only
// - range bit 6: low or high range
// - low range: 0.8 V floor, 25 mV steps
// - code zero selects external adjustable mode
// - buck b same layout at 20h-23h
// - buck b range bit, identical decoding
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps

module buck_regulator_control_regs
	import buck_regs_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [DATA_W-1:0]    s_axi_wdata,
	input  wire logic [DATA_W/8-1:0]  s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 standbyPin,
	input  wire logic [NUM_BUCK-1:0]  powerGoodPin,
	output logic [NUM_BUCK-1:0]       regulatorEnable,
	output logic [NUM_BUCK-1:0]       faultReportMask,
	output logic [NUM_BUCK-1:0]       rangeSelect,
	output logic [NUM_BUCK-1:0]       adjustableMode,
	output logic [5:0]                activeCodeA,
	output logic [5:0]                activeCodeB,
	output logic [MV_W-1:0]           targetMvA,
	output logic [MV_W-1:0]           targetMvB
);

	// decoded access: valid, regulator, register within group
	typedef struct packed {
		logic hit;
		logic buck;
		logic [1:0] sel;
	} decode_t;

	function automatic decode_t decodeAddr(input logic [ADDR_W-1:0] addr);
		decode_t d;
		logic [5:0] idx;
		idx = addr[ADDR_W-1:2];
		d.buck = (idx[5:2] == IDX_B_STANDBY[5:2]);
		d.hit = (idx[5:2] == IDX_A_STANDBY[5:2]) || d.buck;
		d.sel = idx[1:0];
		return d;
	endfunction

	// code and range to target voltage in millivolts
	function automatic logic [MV_W-1:0] codeToMv(input logic [5:0] code, input logic hi);
		logic [MV_W-1:0] c;
		c = {{(MV_W-6){1'b0}}, code};
		if (code == CODE_ADJUSTABLE) begin
			codeToMv = '0;
		end else if (hi) begin
			codeToMv = MV_W'(HIGH_BASE_MV + (c - 13'h0001) * HIGH_STEP_MV);
		end else if (code <= LOW_FLAT_LAST) begin
			codeToMv = LOW_BASE_MV;
		end else if (code == LOW_ODD_CODE) begin
			codeToMv = LOW_ODD_MV;
		end else begin
			codeToMv = MV_W'(LOW_BASE_MV + (c - 13'h0007) * LOW_STEP_MV);
		end
	endfunction

	// ---- pin synchronisers
	logic [2:0] standbySync;
	logic [2:0] pgSyncA;
	logic [2:0] pgSyncB;
	logic standbyLevel;
	logic [NUM_BUCK-1:0] powerGood;
	logic [2:0] next_standbySync;
	logic [2:0] next_pgSyncA;
	logic [2:0] next_pgSyncB;
	logic next_standbyLevel;
	logic [NUM_BUCK-1:0] next_powerGood;

	always_comb begin
		next_standbySync = {standbySync[1:0], standbyPin};
		next_pgSyncA = {pgSyncA[1:0], powerGoodPin[0]};
		next_pgSyncB = {pgSyncB[1:0], powerGoodPin[1]};
		next_standbyLevel = standbyLevel;
		next_powerGood = powerGood;
		if (standbySync[1] == standbySync[2]) begin
			next_standbyLevel = standbySync[2];
		end
		if (pgSyncA[1] == pgSyncA[2]) begin
			next_powerGood[0] = pgSyncA[2];
		end
		if (pgSyncB[1] == pgSyncB[2]) begin
			next_powerGood[1] = pgSyncB[2];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			standbySync <= 3'h0;
			pgSyncA <= 3'h0;
			pgSyncB <= 3'h0;
			standbyLevel <= 1'b0;
			powerGood <= '0;
		end else begin
			standbySync <= next_standbySync;
			pgSyncA <= next_pgSyncA;
			pgSyncB <= next_pgSyncB;
			standbyLevel <= next_standbyLevel;
			powerGood <= next_powerGood;
		end
	end

	// ---- write channel and register storage
	logic awHeld;
	logic wHeld;
	logic [ADDR_W-1:0] awAddr;
	logic [7:0] wByte;
	logic wLane0;
	logic bValid;
	logic [1:0] bResp;
	logic [5:0] standbyCode [NUM_BUCK];
	logic [5:0] mainCode [NUM_BUCK];
	logic [NUM_BUCK-1:0] rangeSel;
	logic [NUM_BUCK-1:0] enable;
	logic [NUM_BUCK-1:0] fmask;
	logic next_awHeld;
	logic next_wHeld;
	logic [ADDR_W-1:0] next_awAddr;
	logic [7:0] next_wByte;
	logic next_wLane0;
	logic next_bValid;
	logic [1:0] next_bResp;
	logic [5:0] next_standbyCode [NUM_BUCK];
	logic [5:0] next_mainCode [NUM_BUCK];
	logic [NUM_BUCK-1:0] next_rangeSel;
	logic [NUM_BUCK-1:0] next_enable;
	logic [NUM_BUCK-1:0] next_fmask;
	decode_t wDec;

	assign s_axi_awready = !awHeld && !bValid;
	assign s_axi_wready = !wHeld && !bValid;
	assign s_axi_bvalid = bValid;
	assign s_axi_bresp = bResp;

	always_comb begin
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_awAddr = awAddr;
		next_wByte = wByte;
		next_wLane0 = wLane0;
		next_bValid = bValid;
		next_bResp = bResp;
		next_standbyCode = standbyCode;
		next_mainCode = mainCode;
		next_rangeSel = rangeSel;
		next_enable = enable;
		next_fmask = fmask;
		wDec = decodeAddr(awAddr);
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wByte = s_axi_wdata[7:0];
			next_wLane0 = s_axi_wstrb[0];
		end
		if (bValid && s_axi_bready) begin
			next_bValid = 1'b0;
		end
		// commit once both halves are held
		if (awHeld && wHeld && !bValid) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bValid = 1'b1;
			next_bResp = wDec.hit ? RESP_OKAY : RESP_SLVERR;
			if (wDec.hit && wLane0) begin
				case (wDec.sel)
					IDX_A_STANDBY[1:0]: begin
						next_standbyCode[wDec.buck] = wByte[CODE_MSB:0];
					end
					IDX_A_CONTROL[1:0]: begin
						next_enable[wDec.buck] = wByte[CTRL_ENABLE_BIT];
						next_fmask[wDec.buck] = wByte[CTRL_FMASK_BIT];
					end
					IDX_A_MAIN[1:0]: begin
						next_mainCode[wDec.buck] = wByte[CODE_MSB:0];
						next_rangeSel[wDec.buck] = wByte[MAIN_RANGE_BIT];
					end
					default: begin
						// reserved byte ignores writes
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= '0;
			wByte <= 8'h00;
			wLane0 <= 1'b0;
			bValid <= 1'b0;
			bResp <= RESP_OKAY;
			for (int i = 0; i < NUM_BUCK; i++) begin
				standbyCode[i] <= RST_CODE;
				mainCode[i] <= RST_CODE;
			end
			rangeSel <= {NUM_BUCK{RST_RANGE}};
			enable <= {NUM_BUCK{RST_ENABLE}};
			fmask <= {NUM_BUCK{RST_FMASK}};
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddr <= next_awAddr;
			wByte <= next_wByte;
			wLane0 <= next_wLane0;
			bValid <= next_bValid;
			bResp <= next_bResp;
			standbyCode <= next_standbyCode;
			mainCode <= next_mainCode;
			rangeSel <= next_rangeSel;
			enable <= next_enable;
			fmask <= next_fmask;
		end
	end

	// ---- read channel
	logic rValid;
	logic [7:0] rByte;
	logic [1:0] rResp;
	logic next_rValid;
	logic [7:0] next_rByte;
	logic [1:0] next_rResp;
	decode_t rDec;

	assign s_axi_arready = !rValid;
	assign s_axi_rvalid = rValid;
	assign s_axi_rresp = rResp;
	assign s_axi_rdata = {{(DATA_W-8){1'b0}}, rByte};

	always_comb begin
		next_rValid = rValid;
		next_rByte = rByte;
		next_rResp = rResp;
		rDec = decodeAddr(s_axi_araddr);
		if (rValid && s_axi_rready) begin
			next_rValid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rValid = 1'b1;
			next_rResp = rDec.hit ? RESP_OKAY : RESP_SLVERR;
			next_rByte = 8'h00;
			if (rDec.hit) begin
				case (rDec.sel)
					IDX_A_STANDBY[1:0]: begin
						next_rByte[CODE_MSB:0] = standbyCode[rDec.buck];
					end
					IDX_A_CONTROL[1:0]: begin
						next_rByte[CTRL_ENABLE_BIT] = enable[rDec.buck];
						next_rByte[CTRL_PGOOD_BIT] = powerGood[rDec.buck];
						next_rByte[CTRL_FMASK_BIT] = fmask[rDec.buck];
					end
					IDX_A_MAIN[1:0]: begin
						next_rByte[CODE_MSB:0] = mainCode[rDec.buck];
						next_rByte[MAIN_RANGE_BIT] = rangeSel[rDec.buck];
					end
					default: begin
						next_rByte = RESERVED_VALUE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rValid <= 1'b0;
			rByte <= 8'h00;
			rResp <= RESP_OKAY;
		end else begin
			rValid <= next_rValid;
			rByte <= next_rByte;
			rResp <= next_rResp;
		end
	end

	// ---- regulator side outputs
	// the host must keep the target inside the present range before
	// flipping range; the bank applies a range change at once
	logic [5:0] next_activeCodeA;
	logic [5:0] next_activeCodeB;
	logic [MV_W-1:0] next_targetMvA;
	logic [MV_W-1:0] next_targetMvB;
	logic [NUM_BUCK-1:0] next_adjustableMode;

	always_comb begin
		next_activeCodeA = standbyLevel ? standbyCode[0] : mainCode[0];
		next_activeCodeB = standbyLevel ? standbyCode[1] : mainCode[1];
		next_targetMvA = codeToMv(next_activeCodeA, rangeSel[0]);
		next_targetMvB = codeToMv(next_activeCodeB, rangeSel[1]);
		next_adjustableMode[0] = (next_activeCodeA == CODE_ADJUSTABLE);
		next_adjustableMode[1] = (next_activeCodeB == CODE_ADJUSTABLE);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			activeCodeA <= RST_CODE;
			activeCodeB <= RST_CODE;
			targetMvA <= '0;
			targetMvB <= '0;
			adjustableMode <= '0;
			regulatorEnable <= '0;
			faultReportMask <= '0;
			rangeSelect <= '0;
		end else begin
			activeCodeA <= next_activeCodeA;
			activeCodeB <= next_activeCodeB;
			targetMvA <= next_targetMvA;
			targetMvB <= next_targetMvB;
			adjustableMode <= next_adjustableMode;
			regulatorEnable <= enable;
			faultReportMask <= fmask;
			rangeSelect <= rangeSel;
		end
	end

endmodule

// ### test/buck_regs_monitor.sv
// buck_regs_monitor: handshake and decode checks on the register bank ports
// assumes a bind onto buck_regulator_control_regs, one clock, rst synchronous
`timescale 1ns/10ps
module buck_regs_monitor
	import buck_regs_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [1:0]        rangeSelect,
	input wire logic [1:0]        adjustableMode,
	input wire logic [5:0]        activeCodeA,
	input wire logic [MV_W-1:0]   targetMvA
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped");
	a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write not answered");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_adjust_zero: assert property (adjustableMode[0] |-> targetMvA == 13'h0000)
		else $error("adjustable mode with fixed target");
	a_low_range: assert property (!rangeSelect[0] && activeCodeA != 6'h00 && $stable(activeCodeA)
		&& $stable(rangeSelect) |-> targetMvA >= 13'h0320 && targetMvA <= 13'h0898)
		else $error("low range target out of bounds");
	a_high_range: assert property (rangeSelect[0] && activeCodeA != 6'h00 && $stable(activeCodeA)
		&& $stable(rangeSelect) |-> targetMvA >= 13'h0514 && targetMvA <= 13'h1130)
		else $error("high range target out of bounds");

	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
	c_high: cover property (rangeSelect[0] && !adjustableMode[0]);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind buck_regulator_control_regs buck_regs_monitor u_buck_regs_monitor (.*);

// ### test/test_buck_regulator_control_regs.sv
// test_buck_regulator_control_regs: register access and voltage decode tests
// assumes buck_regs_pkg compiled first and the monitor bound onto the bank
`timescale 1ns/10ps
module test_buck_regulator_control_regs
	import buck_regs_pkg::*;
;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic [ADDR_W-1:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [DATA_W-1:0]   s_axi_wdata = '0, s_axi_rdata, data;
	logic [3:0]          s_axi_wstrb = '0;
	logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, standbyPin = 1'b0;
	logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]          s_axi_bresp, s_axi_rresp, resp, regulatorEnable, faultReportMask;
	logic [1:0]          powerGoodPin = 2'b00, rangeSelect, adjustableMode;
	logic [5:0]          activeCodeA, activeCodeB;
	logic [MV_W-1:0]     targetMvA, targetMvB;
	logic [7:0]          addrs [8] = '{8'h40, 8'h44, 8'h48, 8'h4c, 8'h80, 8'h84, 8'h88, 8'h8c};
	logic [7:0]          ones [8] = '{8'h3f, 8'h00, 8'h07, 8'h7f, 8'h3f, 8'h00, 8'h05, 8'h7f};
	int                  num_errors = 0, comparisons = 0, cycles = 0;

	buck_regulator_control_regs u_buck_regulator_control_regs (.*);

	always #50 clk = ~clk;

	task automatic wrap_up;
		$display("mismatches %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
		comparisons++;
		if (got !== expv) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, expv, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		data = s_axi_rdata;
		resp = s_axi_rresp;
	endtask

	// expected target in millivolts, 0 for adjustable
	function automatic logic [12:0] mv(input logic hi, input logic [5:0] c);
		if (c == 6'h00)
			return 13'h0000;
		if (hi)
			return 13'h0514 + (c - 6'h01) * 13'h0032;
		if (c == 6'h22)
			return 13'h05c8;
		if (c < 6'h08)
			return 13'h0320;
		return 13'h0320 + (c - 6'h07) * 13'h0019;
	endfunction

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		powerGoodPin <= 2'h1;
		rd(8'h40);
		chk("standby reset", 32'h0, data);
		for (int i = 0; i < 8; i++) begin
			wr(addrs[i], 32'hffffffff, 4'hf);
			chk("write resp", {30'h0, RESP_OKAY}, resp);
		end
		for (int i = 0; i < 8; i++) begin
			rd(addrs[i]);
			chk("read ones", ones[i], data);
			chk("read resp", {30'h0, RESP_OKAY}, resp);
		end
		chk("enable on", 2'h3, regulatorEnable);
		chk("mask on", 2'h3, faultReportMask);
		for (int i = 0; i < 8; i++)
			wr(addrs[i], 32'h0, 4'hf);
		for (int i = 0; i < 8; i++) begin
			rd(addrs[i]);
			chk("read zeros", (addrs[i] == 8'h48) ? 8'h02 : 8'h00, data);
		end
		chk("enable off", 2'h0, regulatorEnable);
		chk("mask off", 2'h0, faultReportMask);
		wr(8'h40, 32'h15, 4'h0);
		chk("no strobe resp", {30'h0, RESP_OKAY}, resp);
		rd(8'h40);
		chk("no strobe", 32'h0, data);
		wr(8'h30, 32'hff, 4'hf);
		chk("unmapped wr", {30'h0, RESP_SLVERR}, resp);
		rd(8'h30);
		chk("unmapped rd", {30'h0, RESP_SLVERR}, resp);
		chk("unmapped data", 32'h0, data);
		// range kept with each code write, so no stray target appears
		for (int h = 0; h < 2; h++)
			for (int c = 0; c < 64; c++) begin
				wr(8'h4c, {25'h0, h[0], c[5:0]}, 4'hf);
				wr(8'h8c, {25'h0, h[0], ~c[5:0]}, 4'hf);
				repeat (3) @(posedge clk);
				chk("target a", mv(h[0], c[5:0]), targetMvA);
				chk("target b", mv(h[0], ~c[5:0]), targetMvB);
				chk("adjust", {~c[5:0] == 6'h00, c[5:0] == 6'h00}, adjustableMode);
				chk("range", {h[0], h[0]}, rangeSelect);
			end
		wr(8'h40, 32'h0a, 4'hf);
		wr(8'h80, 32'h11, 4'hf);
		standbyPin <= 1'b1;
		repeat (8) @(posedge clk);
		chk("standby a", 6'h0a, activeCodeA);
		chk("standby b", 6'h11, activeCodeB);
		chk("standby mv", mv(1'b1, 6'h0a), targetMvA);
		chk("standby mv b", mv(1'b1, 6'h11), targetMvB);
		standbyPin <= 1'b0;
		powerGoodPin <= 2'h2;
		repeat (8) @(posedge clk);
		chk("main a", 6'h3f, activeCodeA);
		chk("main b", 6'h00, activeCodeB);
		rd(8'h48);
		chk("pgood a", 32'h00, data);
		rd(8'h88);
		chk("pgood b", 32'h02, data);
		wrap_up();
	end
endmodule
